// ==== crm_master_model.sv ====
/* Access master model: one request at a time, answer captured.
   Assumes the answer comes one cycle after each taken request. */
`timescale 1ns/100ps
module crm_master_model (
  // Clock
  input wire logic clk,
  // Request
  output logic acc_req,
  output logic acc_we,
  output logic acc_mapped,
  output logic acc_alt,
  output logic [31:0] acc_addr,
  output logic [5:0] acc_group,
  output logic [4:0] acc_index,
  output logic [1:0] acc_size,
  output logic [127:0] acc_wdata,
  // Answer
  input wire logic acc_ack,
  input wire logic acc_err,
  input wire logic [127:0] acc_rdata
);
  logic [127:0] rd_q;
  logic er_q, to_q;
  initial {acc_req, acc_we, acc_mapped, acc_alt, acc_addr, acc_group, acc_index, acc_size, acc_wdata} = '0;
  task automatic xfer(input logic w, m, al, input logic [31:0] a, input logic [5:0] g, input logic [4:0] i,
                      input logic [1:0] s, input logic [127:0] d);
    int n;
    @(posedge clk);
    {acc_req, acc_we, acc_mapped, acc_alt} <= {1'b1, w, m, al};
    {acc_addr, acc_group, acc_index, acc_size, acc_wdata} <= {a, g, i, s, d};
    @(posedge clk);
    acc_req <= 0;
    // Released data shows the inverse
    acc_wdata <= ~d;
    #1;
    for (n = 0; n < 4 && acc_ack !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    to_q = acc_ack !== 1'b1;
    rd_q = acc_rdata;
    er_q = acc_err;
  endtask
endmodule

// ==== crm_params.svh ====
/*
 Constants of the register group map: groups, index limits, flag bits, owner masks, shifts.
 Assumes inclusion by bare name.
*/
// Function
// - Broadcast writes same word into both blocks
// - Words 0x180000-0x18001F reach block A file
// - Words 0x180040-0x18005F reach block B file
// - Merged AB and BA decoded; alternatives unmapped
// - Words 0x180100-0x18011F decode as broadcast group
// - Odd alternative groups only via load/store paths
// - Unmapped registers move only by compute transfers
// - Block status flags update on owner unit completion
// - Two 32-bit parallel result registers per block
// - 64-bit bit FIFO overflow held for bit insert
// - Sixteen 32-bit trellis data registers per block
// - Add compare select shifts history, loads decisions
// - History shift four for 32-bit, eight 16-bit
// - Integer general group holds thirty-two words
// - Unit A files at groups 0x0C and 0x0E
// - Unit B files at groups 0x0D and 0x0F
// - Circular file: bases 0-3, lengths 4-7, rest reserved
// - Integer status: zero, negative, overflow, carry bits
// - Index 31 writes status, reads zero as operand
// - Unit B status same layout at index 31
// - Merged quad two words each, long one each
// - Sixty-four groups of up to thirty-two registers
`ifndef CRM_PARAMS_SVH
`define CRM_PARAMS_SVH

`define CRM_MAP_PAGE 21'h000300
`define CRM_GRP_CB_A 6'h00
`define CRM_GRP_CB_B 6'h02
`define CRM_GRP_MERGE_AB 6'h04
`define CRM_GRP_MERGE_BA 6'h06
`define CRM_GRP_BCAST 6'h08
`define CRM_GRP_CB_LIMIT 6'h0a
`define CRM_GRP_INT_A 6'h0c
`define CRM_GRP_INT_B 6'h0d
`define CRM_GRP_CIRC_A 6'h0e
`define CRM_GRP_CIRC_B 6'h0f
`define CRM_GRP_INT_HI 4'h3

`define CRM_INT_STATUS_IDX 5'h1f
`define CRM_CIRC_USED 5'h08

`define CRM_FLAG_ZERO 0
`define CRM_FLAG_NEG 1
`define CRM_FLAG_OVF 2
`define CRM_FLAG_CARRY 3
`define CRM_STATUS_RST 32'h00000000

`define CRM_OWN_ALU 32'h000000ff
`define CRM_OWN_MUL 32'h0000ff00
`define CRM_OWN_SHF 32'h00ff0000
`define CRM_OWN_COMM 32'hff000000

`define CRM_ACS_SHIFT_32 4
`define CRM_ACS_SHIFT_16 8

`endif

// ==== crm_pkg.sv ====
/*
 Types of the register group map: transfer sizes, unmapped selects.
 Assumes nothing of its surroundings.
*/
package crm_pkg;

  typedef enum logic [1:0] {
    CRM_SIZE_NORMAL,
    CRM_SIZE_LONG,
    CRM_SIZE_QUAD,
    CRM_SIZE_BAD
  } crm_size_type;

  typedef enum logic [1:0] {
    CRM_UM_PRES,
    CRM_UM_BFO,
    CRM_UM_TRELLIS,
    CRM_UM_THR
  } crm_um_sel_type;

endpackage

// ==== crm_regfile.sv ====
/*
 One 32-word register file: a four-lane access port and an operand read port.
 Assumes lane masks match the index.
*/
`timescale 1ns/100ps
module crm_regfile #(
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Access port
  crm_rf_if.file rf
);

  logic [31:0] mem_reg [0:31];

  if (DEPTH != 32) begin : g_check
    $error("only 32 entries served");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        mem_reg[i] <= 32'h0;
      end
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (rf.wr_mask[k]) begin
          mem_reg[rf.idx + 5'(k)] <= rf.wdata[32*k +: 32];
        end
      end
    end
  end

  for (genvar k = 0; k < 4; k++) begin : g_rd
    assign rf.rdata[32*k +: 32] = mem_reg[rf.idx + 5'(k)];
  end
  assign rf.op_rdata = mem_reg[rf.op_idx];

endmodule

// ==== crm_regmap.sv ====
/*
 Compute and integer register groups: decode, merged and broadcast paths, status, unmapped registers.
 Assumes all inputs come from logic on clk.
*/
`timescale 1ns/100ps
`include "crm_params.svh"
module crm_regmap (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access port
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic acc_mapped,
  input wire logic acc_alt,
  input wire logic [31:0] acc_addr,
  input wire logic [5:0] acc_group,
  input wire logic [4:0] acc_index,
  input wire logic [1:0] acc_size,
  input wire logic [127:0] acc_wdata,
  output logic acc_ack,
  output logic acc_err,
  output logic [127:0] acc_rdata,
  // Block status
  input wire logic [3:0] blk_a_unit_done,
  input wire logic [31:0] blk_a_unit_flags,
  input wire logic [3:0] blk_b_unit_done,
  input wire logic [31:0] blk_b_unit_flags,
  output logic [31:0] block_a_status,
  output logic [31:0] block_b_status,
  // Integer flags and operands
  input wire logic int_a_flag_we,
  input wire logic [3:0] int_a_flags,
  input wire logic int_b_flag_we,
  input wire logic [3:0] int_b_flags,
  input wire logic [4:0] int_a_op_index,
  input wire logic [4:0] int_b_op_index,
  output logic [31:0] int_a_status,
  output logic [31:0] int_b_status,
  output logic [31:0] int_a_operand,
  output logic [31:0] int_b_operand,
  // Unmapped register moves
  input wire logic um_we,
  input wire logic um_block,
  input wire logic [1:0] um_sel,
  input wire logic [3:0] um_index,
  input wire logic [63:0] um_wdata,
  output logic [63:0] um_rdata,
  // Unit results
  input wire logic psum_we,
  input wire logic psum_block,
  input wire logic psum_sel,
  input wire logic [31:0] psum_data,
  input wire logic bfo_we,
  input wire logic bfo_block,
  input wire logic [63:0] bfo_data,
  input wire logic acs_valid,
  input wire logic acs_block,
  input wire logic acs_half,
  input wire logic [7:0] acs_decisions
);

  localparam int RF_CB_A = 0;
  localparam int RF_CB_B = 1;
  localparam int RF_INT_A = 2;
  localparam int RF_INT_B = 3;
  localparam int RF_CIRC_A = 4;
  localparam int RF_CIRC_B = 5;

  function automatic logic [127:0] lane_fill(input logic [3:0] m);
    lane_fill = {{32{m[3]}}, {32{m[2]}}, {32{m[1]}}, {32{m[0]}}};
  endfunction

  function automatic logic [31:0] fold_lanes(input logic [127:0] d);
    fold_lanes = d[31:0] | d[63:32] | d[95:64] | d[127:96];
  endfunction

  function automatic logic [31:0] status_word(input logic [3:0] f);
    status_word = {28'h0, f[`CRM_FLAG_CARRY], f[`CRM_FLAG_OVF], f[`CRM_FLAG_NEG], f[`CRM_FLAG_ZERO]};
  endfunction

  function automatic logic [31:0] owned_flags(input logic [3:0] done);
    owned_flags = ({32{done[0]}} & `CRM_OWN_ALU) | ({32{done[1]}} & `CRM_OWN_MUL) |
                  ({32{done[2]}} & `CRM_OWN_SHF) | ({32{done[3]}} & `CRM_OWN_COMM);
  endfunction

  crm_rf_if rf_bus [6] ();
  for (genvar g = 0; g < 6; g++) begin : g_rf
    crm_regfile #(.DEPTH(32)) u_rf (
      .clk(clk),
      .rst(rst),
      .rf(rf_bus[g])
    );
  end

  wire in_map = acc_addr[31:11] == `CRM_MAP_PAGE;
  wire [5:0] group = acc_mapped ? acc_addr[10:5] : acc_group;
  wire [4:0] index = acc_mapped ? acc_addr[4:0] : acc_index;
  wire is_cb = group < `CRM_GRP_CB_LIMIT;
  wire cb_alt = is_cb & group[0];
  wire [5:0] cb_base = {group[5:1], 1'b0};
  wire is_int = group[5:2] == `CRM_GRP_INT_HI;
  wire grp_cb_a = is_cb & (cb_base == `CRM_GRP_CB_A);
  wire grp_cb_b = is_cb & (cb_base == `CRM_GRP_CB_B);
  wire grp_merge = is_cb & ((cb_base == `CRM_GRP_MERGE_AB) | (cb_base == `CRM_GRP_MERGE_BA));
  wire merge_rev = cb_base == `CRM_GRP_MERGE_BA;
  wire grp_bcast = is_cb & (cb_base == `CRM_GRP_BCAST);
  wire grp_int_a = group == `CRM_GRP_INT_A;
  wire grp_int_b = group == `CRM_GRP_INT_B;
  wire grp_circ_a = group == `CRM_GRP_CIRC_A;
  wire grp_circ_b = group == `CRM_GRP_CIRC_B;

  // Alternative groups only for load/store
  wire alt_ok = !cb_alt | (!acc_mapped & acc_alt);
  wire grp_ok = is_int | (is_cb & alt_ok);
  wire map_ok = !acc_mapped | in_map;

  wire sz_normal = acc_size == crm_pkg::CRM_SIZE_NORMAL;
  wire sz_long = acc_size == crm_pkg::CRM_SIZE_LONG;
  wire sz_quad = acc_size == crm_pkg::CRM_SIZE_QUAD;
  wire sz_bad = !(sz_normal | sz_long | sz_quad);
  wire align_reg = sz_quad ? (index[1:0] == 2'h0) : (sz_long ? !index[0] : 1'b1);
  wire align_merge = sz_quad ? !index[0] : 1'b1;
  wire align_ok = grp_merge ? align_merge : align_reg;
  wire merge_bad = grp_merge & sz_normal;
  wire bcast_rd = grp_bcast & !acc_we;
  wire acc_bad = !map_ok | !grp_ok | sz_bad | !align_ok | merge_bad | bcast_rd;
  wire acc_go = acc_req & !acc_bad;
  wire acc_wr = acc_go & acc_we;

  wire [3:0] mask_full = sz_quad ? 4'hf : (sz_long ? 4'h3 : 4'h1);
  wire [3:0] mask_half = sz_quad ? 4'h3 : 4'h1;

  // Merged split: upper half to the first block
  wire [127:0] half_hi = sz_quad ? {64'h0, acc_wdata[127:64]} : {96'h0, acc_wdata[63:32]};
  wire [127:0] half_lo = sz_quad ? {64'h0, acc_wdata[63:0]} : {96'h0, acc_wdata[31:0]};
  wire [127:0] cb_a_wdata = grp_merge ? (merge_rev ? half_lo : half_hi) : acc_wdata;
  wire [127:0] cb_b_wdata = grp_merge ? (merge_rev ? half_hi : half_lo) : acc_wdata;

  // Broadcast: same word and mask into both files
  wire [3:0] cb_a_mask = {4{acc_wr}} & ((grp_cb_a | grp_bcast) ? mask_full :
                         (grp_merge ? mask_half : 4'h0));
  wire [3:0] cb_b_mask = {4{acc_wr}} & ((grp_cb_b | grp_bcast) ? mask_full :
                         (grp_merge ? mask_half : 4'h0));

  wire [3:0] lane_st;
  wire [3:0] lane_circ;
  for (genvar k = 0; k < 4; k++) begin : g_lane
    assign lane_st[k] = (index + 5'(k)) == `CRM_INT_STATUS_IDX;
    assign lane_circ[k] = (index + 5'(k)) < `CRM_CIRC_USED;
  end

  // Index 31 is the status register
  wire [3:0] st_sel = mask_full & lane_st;
  wire st_hit = |st_sel;
  wire [31:0] st_wword = fold_lanes(acc_wdata & lane_fill(st_sel));
  wire [3:0] int_a_mask = {4{acc_wr & grp_int_a}} & mask_full & ~lane_st;
  wire [3:0] int_b_mask = {4{acc_wr & grp_int_b}} & mask_full & ~lane_st;
  wire [3:0] circ_a_mask = {4{acc_wr & grp_circ_a}} & mask_full & lane_circ;
  wire [3:0] circ_b_mask = {4{acc_wr & grp_circ_b}} & mask_full & lane_circ;

  assign rf_bus[RF_CB_A].wr_mask = cb_a_mask;
  assign rf_bus[RF_CB_A].wdata = cb_a_wdata;
  assign rf_bus[RF_CB_B].wr_mask = cb_b_mask;
  assign rf_bus[RF_CB_B].wdata = cb_b_wdata;
  assign rf_bus[RF_INT_A].wr_mask = int_a_mask;
  assign rf_bus[RF_INT_A].wdata = acc_wdata;
  assign rf_bus[RF_INT_B].wr_mask = int_b_mask;
  assign rf_bus[RF_INT_B].wdata = acc_wdata;
  assign rf_bus[RF_CIRC_A].wr_mask = circ_a_mask;
  assign rf_bus[RF_CIRC_A].wdata = acc_wdata;
  assign rf_bus[RF_CIRC_B].wr_mask = circ_b_mask;
  assign rf_bus[RF_CIRC_B].wdata = acc_wdata;
  for (genvar g = 0; g < 6; g++) begin : g_idx
    assign rf_bus[g].idx = index;
  end
  assign rf_bus[RF_CB_A].op_idx = 5'h00;
  assign rf_bus[RF_CB_B].op_idx = 5'h00;
  assign rf_bus[RF_INT_A].op_idx = int_a_op_index;
  assign rf_bus[RF_INT_B].op_idx = int_b_op_index;
  assign rf_bus[RF_CIRC_A].op_idx = 5'h00;
  assign rf_bus[RF_CIRC_B].op_idx = 5'h00;

  wire [127:0] rd_a = rf_bus[RF_CB_A].rdata;
  wire [127:0] rd_b = rf_bus[RF_CB_B].rdata;
  wire [127:0] rd_first = merge_rev ? rd_b : rd_a;
  wire [127:0] rd_second = merge_rev ? rd_a : rd_b;
  wire [127:0] rd_merge = sz_quad ? {rd_first[63:0], rd_second[63:0]} :
                          {64'h0, rd_first[31:0], rd_second[31:0]};
  wire [127:0] fill_full = lane_fill(mask_full);
  wire [127:0] fill_st = lane_fill(lane_st);
  logic [31:0] int_a_status_reg;
  logic [31:0] int_b_status_reg;
  wire [127:0] rd_int_a = (rf_bus[RF_INT_A].rdata & ~fill_st) | (fill_st & {4{int_a_status_reg}});
  wire [127:0] rd_int_b = (rf_bus[RF_INT_B].rdata & ~fill_st) | (fill_st & {4{int_b_status_reg}});
  wire [127:0] fill_circ = lane_fill(lane_circ);
  wire [127:0] rd_sel = grp_cb_a ? rd_a :
                        grp_cb_b ? rd_b :
                        grp_int_a ? rd_int_a :
                        grp_int_b ? rd_int_b :
                        grp_circ_a ? (rf_bus[RF_CIRC_A].rdata & fill_circ) :
                        grp_circ_b ? (rf_bus[RF_CIRC_B].rdata & fill_circ) : 128'h0;
  wire [127:0] rd_word = grp_merge ? rd_merge : (rd_sel & fill_full);
  wire [127:0] acc_rdata_next = (acc_go & !acc_we) ? rd_word : 128'h0;

  logic acc_ack_reg;
  logic acc_err_reg;
  logic [127:0] acc_rdata_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ack_reg <= 1'b0;
      acc_err_reg <= 1'b0;
      acc_rdata_reg <= 128'h0;
    end else begin
      acc_ack_reg <= acc_req;
      acc_err_reg <= acc_req & acc_bad;
      acc_rdata_reg <= acc_rdata_next;
    end
  end

  // Integer status: a flag update beats a register write
  wire [31:0] int_a_status_next = int_a_flag_we ? status_word(int_a_flags) :
                                  (acc_wr & grp_int_a & st_hit) ? status_word(st_wword[3:0]) :
                                  int_a_status_reg;
  wire [31:0] int_b_status_next = int_b_flag_we ? status_word(int_b_flags) :
                                  (acc_wr & grp_int_b & st_hit) ? status_word(st_wword[3:0]) :
                                  int_b_status_reg;

  // Operand index 31 reads zero
  wire [31:0] int_a_operand_next = (int_a_op_index == `CRM_INT_STATUS_IDX) ? 32'h0 :
                                   rf_bus[RF_INT_A].op_rdata;
  wire [31:0] int_b_operand_next = (int_b_op_index == `CRM_INT_STATUS_IDX) ? 32'h0 :
                                   rf_bus[RF_INT_B].op_rdata;

  logic [31:0] int_a_operand_reg;
  logic [31:0] int_b_operand_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_a_status_reg <= `CRM_STATUS_RST;
      int_b_status_reg <= `CRM_STATUS_RST;
      int_a_operand_reg <= 32'h0;
      int_b_operand_reg <= 32'h0;
    end else begin
      int_a_status_reg <= int_a_status_next;
      int_b_status_reg <= int_b_status_next;
      int_a_operand_reg <= int_a_operand_next;
      int_b_operand_reg <= int_b_operand_next;
    end
  end

  // Block status: only flags of finished units change
  logic [31:0] blk_a_status_reg;
  logic [31:0] blk_b_status_reg;
  wire [31:0] own_a = owned_flags(blk_a_unit_done);
  wire [31:0] own_b = owned_flags(blk_b_unit_done);
  wire [31:0] blk_a_status_next = (blk_a_status_reg & ~own_a) | (blk_a_unit_flags & own_a);
  wire [31:0] blk_b_status_next = (blk_b_status_reg & ~own_b) | (blk_b_unit_flags & own_b);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blk_a_status_reg <= `CRM_STATUS_RST;
      blk_b_status_reg <= `CRM_STATUS_RST;
    end else begin
      blk_a_status_reg <= blk_a_status_next;
      blk_b_status_reg <= blk_b_status_next;
    end
  end

  // Unmapped registers: moves and unit results only
  wire um_pres = um_sel == crm_pkg::CRM_UM_PRES;
  wire um_bfo = um_sel == crm_pkg::CRM_UM_BFO;
  wire um_tr = um_sel == crm_pkg::CRM_UM_TRELLIS;
  wire um_thr = um_sel == crm_pkg::CRM_UM_THR;
  logic [31:0] pres_reg [0:1][0:1];
  logic [63:0] bfo_reg [0:1];
  logic [31:0] trellis_reg [0:1][0:15];
  logic [63:0] thr_reg [0:1];

  for (genvar b = 0; b < 2; b++) begin : g_blk
    wire um_hit = um_we & (um_block == 1'(b));
    wire ps_hit = psum_we & (psum_block == 1'(b));
    wire bf_hit = bfo_we & (bfo_block == 1'(b));
    wire acs_hit = acs_valid & (acs_block == 1'(b));
    wire [63:0] thr_shift = acs_half ?
      {acs_decisions[`CRM_ACS_SHIFT_16-1:0], thr_reg[b][63:`CRM_ACS_SHIFT_16]} :
      {acs_decisions[`CRM_ACS_SHIFT_32-1:0], thr_reg[b][63:`CRM_ACS_SHIFT_32]};
    wire [63:0] thr_next = acs_hit ? thr_shift : ((um_hit & um_thr) ? um_wdata : thr_reg[b]);
    wire [63:0] bfo_next = bf_hit ? bfo_data : ((um_hit & um_bfo) ? um_wdata : bfo_reg[b]);

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        thr_reg[b] <= 64'h0;
        bfo_reg[b] <= 64'h0;
      end else begin
        thr_reg[b] <= thr_next;
        bfo_reg[b] <= bfo_next;
      end
    end

    for (genvar p = 0; p < 2; p++) begin : g_pres
      wire ps_sel = ps_hit & (psum_sel == 1'(p));
      wire mv_sel = um_hit & um_pres & (um_index[0] == 1'(p));
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pres_reg[b][p] <= 32'h0;
        end else if (ps_sel) begin
          pres_reg[b][p] <= psum_data;
        end else if (mv_sel) begin
          pres_reg[b][p] <= um_wdata[31:0];
        end
      end
    end

    for (genvar t = 0; t < 16; t++) begin : g_tr
      wire tr_sel = um_hit & um_tr & (um_index == 4'(t));
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          trellis_reg[b][t] <= 32'h0;
        end else if (tr_sel) begin
          trellis_reg[b][t] <= um_wdata[31:0];
        end
      end
    end
  end

  wire [63:0] um_rdata_next = um_pres ? {32'h0, pres_reg[um_block][um_index[0]]} :
                              um_bfo ? bfo_reg[um_block] :
                              um_tr ? {32'h0, trellis_reg[um_block][um_index]} :
                              thr_reg[um_block];
  logic [63:0] um_rdata_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      um_rdata_reg <= 64'h0;
    end else begin
      um_rdata_reg <= um_rdata_next;
    end
  end

  assign acc_ack = acc_ack_reg;
  assign acc_err = acc_err_reg;
  assign acc_rdata = acc_rdata_reg;
  assign block_a_status = blk_a_status_reg;
  assign block_b_status = blk_b_status_reg;
  assign int_a_status = int_a_status_reg;
  assign int_b_status = int_b_status_reg;
  assign int_a_operand = int_a_operand_reg;
  assign int_b_operand = int_b_operand_reg;
  assign um_rdata = um_rdata_reg;

endmodule

// ==== crm_regmap_asserts.sv ====
/* Checker of the register group map.
   Sees only the top module's ports; bound to every instance. */
`timescale 1ns/100ps
module crm_regmap_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Access port
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic acc_mapped,
  input wire logic acc_alt,
  input wire logic [31:0] acc_addr,
  input wire logic [5:0] acc_group,
  input wire logic [1:0] acc_size,
  input wire logic acc_ack,
  input wire logic acc_err,
  input wire logic [127:0] acc_rdata,
  // Status and operands
  input wire logic [3:0] blk_a_unit_done,
  input wire logic [31:0] blk_a_unit_flags,
  input wire logic [31:0] block_a_status,
  input wire logic int_a_flag_we,
  input wire logic [3:0] int_a_flags,
  input wire logic int_b_flag_we,
  input wire logic [3:0] int_b_flags,
  input wire logic [4:0] int_a_op_index,
  input wire logic [31:0] int_a_status,
  input wire logic [31:0] int_b_status,
  input wire logic [31:0] int_a_operand
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_ack_one_cycle: assert property (acc_ack == $past(acc_req))
    else $error("ack late");
  chk_bad_page: assert property (acc_req && acc_mapped && acc_addr[31:11] != 21'h000300 |=> acc_err && acc_rdata == '0)
    else $error("off-page access accepted");
  chk_merged_normal: assert property (acc_req && !acc_mapped && acc_group inside {[6'h04:6'h07]} && acc_size == 2'h0 |=> acc_err)
    else $error("merged normal accepted");
  chk_bcast_read: assert property (acc_req && !acc_we && acc_mapped && acc_addr[31:5] == 27'h000c008 |=> acc_err)
    else $error("bcast read accepted");
  chk_alt_refused: assert property ((acc_mapped ? acc_addr[31:11] == 21'h000300 && acc_addr[5] && acc_addr[10:5] < 6'h0a
    : !acc_alt && acc_group[0] && acc_group < 6'h0a) && acc_req |=> acc_err)
    else $error("alternative group accepted");
  chk_int_a_flags: assert property (int_a_flag_we |=> int_a_status == {28'h0, $past(int_a_flags)})
    else $error("unit a flags lost");
  chk_int_b_flags: assert property (int_b_flag_we |=> int_b_status == {28'h0, $past(int_b_flags)})
    else $error("unit b flags lost");
  chk_operand_zero: assert property (int_a_op_index == 5'h1f |=> int_a_operand == 32'h0)
    else $error("operand 31 not zero");
  chk_alu_flags: assert property (blk_a_unit_done[0] |=> block_a_status[7:0] == $past(blk_a_unit_flags[7:0]))
    else $error("alu flags lost");
  chk_status_hold: assert property (blk_a_unit_done == 4'h0 |=> $stable(block_a_status))
    else $error("block status moved");
  cover property (acc_ack && acc_err);
  cover property (acc_ack && !acc_err);
  cover property (int_a_flag_we);
endmodule
bind crm_regmap crm_regmap_asserts chk (.clk, .rst, .acc_req, .acc_we, .acc_mapped, .acc_alt, .acc_addr, .acc_group,
  .acc_size, .acc_ack, .acc_err, .acc_rdata, .blk_a_unit_done, .blk_a_unit_flags, .block_a_status, .int_a_flag_we,
  .int_a_flags, .int_b_flag_we, .int_b_flags, .int_a_op_index, .int_a_status, .int_b_status, .int_a_operand);

// ==== crm_regmap_test.sv ====
/* Bench for the register group map, one task per scenario.
   Assumes the master model drives the access port. */
`timescale 1ns/100ps
module crm_regmap_test;
  logic clk, rst, acc_req, acc_we, acc_mapped, acc_alt, acc_ack, acc_err, int_a_flag_we, int_b_flag_we, um_we;
  logic um_block, psum_we, psum_block, psum_sel, bfo_we, bfo_block, acs_valid, acs_block, acs_half;
  logic [1:0] acc_size, um_sel;
  logic [3:0] blk_a_unit_done, blk_b_unit_done, int_a_flags, int_b_flags, um_index;
  logic [4:0] acc_index, int_a_op_index, int_b_op_index;
  logic [5:0] acc_group;
  logic [7:0] acs_decisions;
  logic [31:0] acc_addr, blk_a_unit_flags, blk_b_unit_flags, block_a_status, block_b_status, int_a_status;
  logic [31:0] int_b_status, int_a_operand, int_b_operand, psum_data;
  logic [63:0] um_wdata, um_rdata, bfo_data;
  logic [127:0] acc_wdata, acc_rdata;
  int err_count = 0, cmp_count = 0;
  crm_regmap dut (.*);
  crm_master_model mdl (.*);
  task automatic chk(input string nm, input logic [127:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic acc(input logic w, m, al, input logic [31:0] a, input logic [5:0] g, input logic [4:0] i,
                     input logic [1:0] s, input logic [127:0] d);
    mdl.xfer(w, m, al, a, g, i, s, d);
    if (mdl.to_q) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic mw(input logic [31:0] a, input logic [1:0] s, input logic [127:0] d);
    acc(1'b1, 1'b1, 1'b0, a, 6'h00, 5'h00, s, d);
  endtask
  task automatic mr(input logic [31:0] a, input logic [1:0] s);
    acc(1'b0, 1'b1, 1'b0, a, 6'h00, 5'h00, s, '0);
  endtask
  task automatic t_acs();
    @(posedge clk);
    {acs_valid, acs_half, acs_decisions, um_sel} <= {1'b1, 1'b0, 8'h09, 2'h3};
    @(posedge clk);
    {acs_half, acs_decisions} <= {1'b1, 8'h3c};
    @(posedge clk);
    acs_valid <= 0;
    #1;
    chk("history", um_rdata, {4'h9, 60'h0});
    @(posedge clk);
    #1;
    chk("history", um_rdata, {8'h3c, 4'h9, 52'h0});
  endtask
  task automatic t_units();
    @(posedge clk);
    {psum_we, psum_block, psum_sel, psum_data} <= {3'b111, 32'h1234abcd};
    {bfo_we, bfo_block, bfo_data, um_block, um_sel, um_index} <= {2'b11, 64'h0123456789abcdef, 1'b1, 2'h0, 4'h1};
    @(posedge clk);
    {psum_we, bfo_we} <= 2'b00;
    @(posedge clk);
    um_sel <= 2'h1;
    #1;
    chk("psum", um_rdata, 128'h1234abcd);
    @(posedge clk);
    {um_we, um_sel, um_index, um_wdata} <= {1'b1, 2'h2, 4'hf, 64'h55aa33cc};
    #1;
    chk("bfo", um_rdata, 128'h0123456789abcdef);
    @(posedge clk);
    um_we <= 0;
    @(posedge clk);
    #1;
    chk("trellis", um_rdata, 128'h55aa33cc);
  endtask
  task automatic t_status();
    @(posedge clk);
    {blk_a_unit_done, blk_a_unit_flags, blk_b_unit_done, blk_b_unit_flags} <= {4'h5, 32'ha5a5a5a5, 4'h8, 32'h3c3c3c3c};
    @(posedge clk);
    {blk_a_unit_done, blk_b_unit_done} <= 8'h00;
    #1;
    chk("status a", block_a_status, 128'h00a500a5);
    chk("status b", block_b_status, 128'h3c000000);
  endtask
  task automatic t_blocks();
    mw(32'h180005, 2'h0, 128'h11111111);
    mw(32'h180045, 2'h0, 128'h22222222);
    mr(32'h180005, 2'h0);
    chk("a5", mdl.rd_q, 128'h11111111);
    acc(1'b0, 1'b0, 1'b0, 32'h0, 6'h02, 5'h05, 2'h0, '0);
    chk("b5", mdl.rd_q, 128'h22222222);
    mw(32'h180103, 2'h0, 128'h33);
    mr(32'h180043, 2'h0);
    chk("bcast b", mdl.rd_q, 128'h33);
    mr(32'h180003, 2'h0);
    chk("bcast a", mdl.rd_q, 128'h33);
    mr(32'h180103, 2'h0);
    chk("bcast read err", mdl.er_q, 1'b1);
    mw(32'h180082, 2'h1, 128'haaaa0000bbbb0000);
    mr(32'h180002, 2'h0);
    chk("merged a", mdl.rd_q, 128'haaaa0000);
    mw(32'h1800c4, 2'h2, 128'h44444444333333332222222211111111);
    mr(32'h180044, 2'h1);
    chk("merged b", mdl.rd_q, 128'h4444444433333333);
    mr(32'h180004, 2'h1);
    chk("merged a", mdl.rd_q, 128'h2222222211111111);
    acc(1'b1, 1'b0, 1'b0, 32'h0, 6'h04, 5'h06, 2'h0, 128'h1);
    chk("merged normal err", mdl.er_q, 1'b1);
    acc(1'b1, 1'b0, 1'b0, 32'h0, 6'h01, 5'h07, 2'h0, 128'h5);
    chk("alt err", mdl.er_q, 1'b1);
    mw(32'h180027, 2'h0, 128'h5);
    chk("alt mapped err", mdl.er_q, 1'b1);
    acc(1'b1, 1'b0, 1'b1, 32'h0, 6'h01, 5'h07, 2'h0, 128'h77);
    acc(1'b0, 1'b0, 1'b1, 32'h0, 6'h01, 5'h07, 2'h0, '0);
    chk("alt read", mdl.rd_q, 128'h77);
    mr(32'h100005, 2'h0);
    chk("page err", mdl.er_q, 1'b1);
    acc(1'b0, 1'b0, 1'b0, 32'h0, 6'h0a, 5'h00, 2'h0, '0);
    chk("group err", mdl.er_q, 1'b1);
  endtask
  task automatic t_int();
    mw(32'h18019f, 2'h0, 128'hffffffff);
    chk("int a status", int_a_status, 128'hf);
    mw(32'h1801bf, 2'h0, 128'h6);
    chk("int b status", int_b_status, 128'h6);
    mw(32'h180185, 2'h0, 128'hcafe);
    mr(32'h18019f, 2'h0);
    chk("int a read", mdl.rd_q, 128'hf);
    mw(32'h1801c4, 2'h0, 128'h1000);
    mw(32'h1801c9, 2'h0, 128'h99);
    mr(32'h1801c4, 2'h0);
    chk("circ a", mdl.rd_q, 128'h1000);
    mr(32'h1801c9, 2'h0);
    chk("circ reserved", mdl.rd_q, 128'h0);
    mw(32'h1801e7, 2'h0, 128'h40);
    mr(32'h1801e7, 2'h0);
    chk("circ b", mdl.rd_q, 128'h40);
    @(posedge clk);
    {int_a_op_index, int_b_op_index} <= {5'h05, 5'h1f};
    {int_a_flag_we, int_a_flags, int_b_flag_we, int_b_flags} <= {1'b1, 4'ha, 1'b1, 4'h3};
    @(posedge clk);
    {int_a_op_index, int_a_flag_we, int_b_flag_we} <= {5'h1f, 2'b00};
    #1;
    chk("operand a", int_a_operand, 128'hcafe);
    chk("operand b", int_b_operand, 128'h0);
    chk("flags a", int_a_status, 128'ha);
    chk("flags b", int_b_status, 128'h3);
    @(posedge clk);
    #1;
    chk("operand a31", int_a_operand, 128'h0);
  endtask
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst = 1;
    {int_a_flag_we, int_b_flag_we, um_we, um_block, psum_we, psum_block, psum_sel, bfo_we, bfo_block} = '0;
    {acs_valid, acs_block, acs_half, um_sel, blk_a_unit_done, blk_b_unit_done, int_a_flags, int_b_flags} = '0;
    {um_index, int_a_op_index, int_b_op_index, acs_decisions, blk_a_unit_flags, blk_b_unit_flags} = '0;
    {psum_data, um_wdata, bfo_data} = '0;
    repeat (2) @(posedge clk);
    rst <= 0;
    t_acs();
    t_units();
    t_status();
    t_blocks();
    t_int();
    end_of_test();
  end
endmodule

// ==== crm_rf_if.sv ====
/*
 Carrier between the decoder and one register file.
 Assumes the decoder drives the control side every cycle.
*/
`timescale 1ns/100ps
interface crm_rf_if;
  logic [3:0] wr_mask;
  logic [4:0] idx;
  logic [127:0] wdata;
  logic [127:0] rdata;
  logic [4:0] op_idx;
  logic [31:0] op_rdata;
  modport file (input wr_mask, idx, wdata, op_idx, output rdata, op_rdata);
  modport ctrl (output wr_mask, idx, wdata, op_idx, input rdata, op_rdata);
endinterface
